// >>> core/ppg_core.sv
// Paired PWM generator: four counter pairs, bridge decoding, trip and register port
//
// Overview of operation
// RULE1 - Eight outputs as four high/low pairs
// RULE2 - Pairs 0,1 bridge capable; 2,3 standard
// RULE3 - Bridge mode selected after reset
// RULE4 - Trip falling edge shuts down at once
// RULE5 - Trip forces high sides high, lows low
// RULE6 - Trip raises interrupt toward software
// RULE7 - Count clock is base divided 2..256
// RULE8 - Prescale code in control bits 8:6
// RULE9 - Base clock from external three-bit divider
// RULE10 - Independent counter, period from length register
// RULE11 - Sixteen-bit counters compared against compare values
// RULE12 - Low side rises at period length
// RULE13 - Low side falls at third compare or high fall
// RULE14 - High side rises first, falls second compare
// RULE15 - Period is length plus one ticks
// RULE16 - Low-side high time from length and compares
// RULE17 - High-side low time first minus second compare
// RULE18 - Software keeps high time above low time
// RULE19 - Standard mode: each pair own registers
// RULE20 - Period per pair, duty per output
// RULE21 - Codes 000..111 give divide 2..256
// RULE22 - Load bit transfers compares, self clears; code clears the bit in standard mode only, in bridge mode it stays set
// RULE23 - Master enable gates all outputs
// RULE24 - Pair interrupt on wrap, write-one clear; code raises no pair 1 interrupt in bridge mode
// RULE25 - Count up from zero, wrap after length
// RULE26 - Registered outputs change on clock only
`timescale 1ns/100ps
module ppg_core (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  // Register port
  input wire ppg_pkg::ppg_bus_s bus_i,
  output logic [15:0] rdata_o,
  // Base clock divider select, held in the clock controller
  input wire logic [2:0] clock_divider_control_i,
  // Fault trip pin, asynchronous
  input wire logic fault_trip_input_i,
  // Modulated outputs, even = high side, odd = low side
  output logic [7:0] pwm_o,
  // Interrupt levels
  output logic irq_trip_o,
  output logic [3:0] irq_pair_o
);

  // State
  logic [15:0] ctrl_q, ctrl_d;
  logic [4:0] stat_q, stat_d;
  ppg_pkg::ppg_pair_s shadow_q [ppg_pkg::NPAIR];
  ppg_pkg::ppg_pair_s active_q [ppg_pkg::NPAIR];
  logic [15:0] cnt_q [ppg_pkg::NPAIR];
  logic [3:0] hs_q, ls_q, wrap, loaded_q, load_now;
  logic [7:0] out_q, out_d;
  logic [7:0] base_div_q, pre_div_q;
  logic trip_s1_q, trip_s2_q, trip_s3_q;
  logic [15:0] rdata_q, rdata_d;

  // Register decode
  wire logic [7:0] addr = bus_i.addr;
  wire logic [7:0] rel_pair = 8'(addr - ppg_pkg::PAIR_BASE);
  wire logic [7:0] rel_cnt = 8'(addr - ppg_pkg::CNT_BASE);
  wire logic aligned = (addr[1:0] == 2'b00);
  wire logic hit_ctrl = aligned && (addr == ppg_pkg::CTRL_OFS);
  wire logic hit_stat = aligned && (addr == ppg_pkg::STAT_OFS);
  wire logic hit_pair = aligned && (addr >= ppg_pkg::PAIR_BASE) && (addr < ppg_pkg::CNT_BASE);
  wire logic hit_cnt = aligned && (addr >= ppg_pkg::CNT_BASE) && (addr < ppg_pkg::CNT_END);
  wire logic [1:0] pidx = rel_pair[5:4];
  wire logic [1:0] fidx = rel_pair[3:2];
  wire logic [1:0] cidx = rel_cnt[3:2];
  wire logic [5:0] fsel = {fidx, 4'h0};

  // Control fields
  wire logic run = ctrl_q[ppg_pkg::EN_BIT];
  wire logic bridge = ctrl_q[ppg_pkg::BRIDGE_MODE_SELECT_BIT];
  wire logic ien = ctrl_q[ppg_pkg::IEN_BIT];
  wire logic load_req = ctrl_q[ppg_pkg::LOAD_BIT];
  wire logic [2:0] pre_sel = ctrl_q[ppg_pkg::PRE_MSB:ppg_pkg::PRE_LSB];

  // Clock dividers: base tick from external code, then prescale by 2^(sel+1)
  wire logic [7:0] base_mask = ppg_pkg::ppg_mask({1'b0, clock_divider_control_i});
  wire logic [7:0] pre_mask = ppg_pkg::ppg_mask(4'({1'b0, pre_sel} + 4'h1));
  wire logic base_tick = ((base_div_q & base_mask) == base_mask); // see RULE9
  wire logic pre_tick = base_tick && ((pre_div_q & pre_mask) == pre_mask); // see RULE7 see RULE21

  // Prescale dividers free-run so a new code takes effect without a reset
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      base_div_q <= 8'h00;
      pre_div_q <= 8'h00;
    end else if (en_i) begin
      base_div_q <= 8'(base_div_q + 8'h01);
      if (base_tick) begin
        pre_div_q <= 8'(pre_div_q + 8'h01); // see RULE8
      end
    end
  end

  // Trip pin synchroniser plus edge stage; the second and third flops are compared for the edge
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      trip_s1_q <= 1'b1;
      trip_s2_q <= 1'b1;
      trip_s3_q <= 1'b1;
    end else if (en_i) begin
      trip_s1_q <= fault_trip_input_i;
      trip_s2_q <= trip_s1_q;
      trip_s3_q <= trip_s2_q;
    end
  end

  wire logic trip_fall = trip_s3_q && !trip_s2_q; // see RULE4

  // Load completes once every pair has taken its new values (standard mode only)
  wire logic load_done = load_req && !bridge && ((loaded_q | load_now) == 4'hF); // see RULE22

  // Control register; trip clearing enable overrides a same-cycle write for safety
  always_comb begin
    ctrl_d = ctrl_q;
    if (load_done) begin
      ctrl_d[ppg_pkg::LOAD_BIT] = 1'b0;
    end
    if (bus_i.we && hit_ctrl) begin
      ctrl_d = bus_i.wdata & ppg_pkg::CTRL_MASK;
    end
    if (trip_fall) begin
      ctrl_d[ppg_pkg::EN_BIT] = 1'b0; // see RULE4
    end
  end

  // Status flags: hardware set wins over a write-one clear
  wire logic [3:0] wrap_irq = wrap & {4{ien}} & {2'b11, !bridge, 1'b1}; // see RULE24
  wire logic [4:0] stat_clr = (bus_i.we && hit_stat) ? bus_i.wdata[4:0] : 5'h00;
  assign stat_d = (stat_q & ~stat_clr) | {trip_fall, wrap_irq}; // see RULE6 see RULE24

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl_q <= ppg_pkg::CTRL_RST; // see RULE3
      stat_q <= ppg_pkg::STAT_RST;
      loaded_q <= 4'h0;
    end else if (en_i) begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      // Bridge mode never tracks, so every wrap reloads while the bit stays set
      loaded_q <= (load_req && !bridge && !load_done) ? (loaded_q | load_now) : 4'h0; // see RULE22
    end
  end

  // Per-pair counter, shadow, active compares and raw waveforms
  for (genvar p = 0; p < ppg_pkg::NPAIR; p++) begin : g_pair
    logic hs_d, ls_d;
    ppg_pkg::ppg_pair_s act;
    assign act = active_q[p];
    assign wrap[p] = run && pre_tick && (cnt_q[p] == act.len); // see RULE25
    assign load_now[p] = load_req && !loaded_q[p] && (wrap[p] || !run); // see RULE22

    // Edge generation at the compare points; fall takes priority on equal values
    always_comb begin
      hs_d = hs_q[p];
      ls_d = ls_q[p];
      if (cnt_q[p] == act.com0) begin
        hs_d = 1'b1; // see RULE14
      end
      if (cnt_q[p] == act.com1) begin
        hs_d = 1'b0; // see RULE14 see RULE17
      end
      if (cnt_q[p] == act.len) begin
        ls_d = 1'b1; // see RULE12 see RULE16
      end
      if ((cnt_q[p] == act.com2) || (hs_q[p] && !hs_d)) begin
        ls_d = 1'b0; // see RULE13
      end
    end

    always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
        cnt_q[p] <= 16'h0000;
        hs_q[p] <= 1'b0;
        ls_q[p] <= 1'b0;
        shadow_q[p] <= '0;
        active_q[p] <= '0;
      end else if (en_i) begin
        if (bus_i.we && hit_pair && (pidx == 2'(p))) begin
          shadow_q[p][fsel +: 16] <= bus_i.wdata;
        end
        if (load_now[p]) begin
          active_q[p] <= shadow_q[p]; // see RULE22
        end
        if (!run) begin
          cnt_q[p] <= 16'h0000;
          hs_q[p] <= 1'b0;
          ls_q[p] <= 1'b0;
        end else if (pre_tick) begin
          cnt_q[p] <= wrap[p] ? 16'h0000 : 16'(cnt_q[p] + 16'h0001); // see RULE10 see RULE11 see RULE15
          hs_q[p] <= hs_d;
          ls_q[p] <= ls_d;
        end
      end
    end
  end

  // Bridge decoding of pairs 0 and 1 from the pair 0 waveforms
  wire logic b_hs = hs_q[0];
  wire logic b_ls = ls_q[0];
  wire logic b_ena = ctrl_q[ppg_pkg::ENA_BIT];
  wire logic b_hoff = ctrl_q[ppg_pkg::HOFF_BIT];
  wire logic b_inv = ctrl_q[ppg_pkg::POINV_BIT];
  wire logic b_dir = ctrl_q[ppg_pkg::DIR_BIT];
  logic [3:0] bridge_out;
  always_comb begin
    if (b_hoff) begin
      bridge_out = 4'b0101;
    end else if (!b_ena) begin
      bridge_out = 4'b1111;
    end else begin
      case ({b_inv, b_dir})
        2'b00: bridge_out = {b_ls, b_hs, 2'b00};
        2'b01: bridge_out = {2'b00, b_ls, b_hs};
        2'b10: bridge_out = {2'b11, b_hs, b_ls};
        default: bridge_out = {b_hs, b_ls, 2'b11};
      endcase
    end
  end

  // Standard mode: each pair drives its own two outputs
  wire logic [7:0] std_out = {ls_q[3], hs_q[3], ls_q[2], hs_q[2], ls_q[1], hs_q[1], ls_q[0], hs_q[0]}; // see RULE19 see RULE20
  wire logic [7:0] mode_out = bridge ? {std_out[7:4], bridge_out} : std_out; // see RULE2
  wire logic trip_hold = stat_q[ppg_pkg::TRIP_BIT] && !run;

  // Output selection: trip off state beats disable, which beats the waveforms
  always_comb begin
    if (trip_fall || trip_hold) begin
      out_d = ppg_pkg::OUT_OFF; // see RULE5
    end else if (!run) begin
      out_d = ppg_pkg::OUT_RST; // see RULE23
    end else begin
      out_d = mode_out; // see RULE1
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 16'h0000;
    if (bus_i.re) begin
      if (hit_ctrl) begin
        rdata_d = ctrl_q;
      end else if (hit_stat) begin
        rdata_d = {11'h000, stat_q};
      end else if (hit_pair) begin
        rdata_d = shadow_q[pidx][fsel +: 16];
      end else if (hit_cnt) begin
        rdata_d = cnt_q[cidx];
      end
    end
  end

  // Output and read data registers, so edges are glitch free
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      out_q <= ppg_pkg::OUT_RST; // see RULE25
      rdata_q <= 16'h0000;
    end else if (en_i) begin
      out_q <= out_d; // see RULE26
      rdata_q <= rdata_d;
    end
  end

  assign pwm_o = out_q;
  assign rdata_o = rdata_q;
  assign irq_trip_o = stat_q[ppg_pkg::TRIP_BIT];
  assign irq_pair_o = stat_q[3:0];

  // Checks
  a_trip_off_out: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE5
    (en_i && trip_fall) |=> (pwm_o == ppg_pkg::OUT_OFF))
    else $error("trip did not force off state");
  a_trip_stops_en: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE4
    (en_i && trip_fall) |=> !ctrl_q[ppg_pkg::EN_BIT] && irq_trip_o)
    else $error("trip did not disable and flag");
  a_trip_latency: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE4
    (en_i && $fell(trip_s2_q)) |=> (pwm_o == ppg_pkg::OUT_OFF))
    else $error("trip shutdown late");
  a_wrap_to_zero: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE25
    (en_i && wrap[2]) |=> (cnt_q[2] == 16'h0000))
    else $error("counter did not wrap to zero");
  a_count_step: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE10
    (en_i && run && pre_tick && !wrap[1] && !trip_fall) |=> (cnt_q[1] == 16'($past(cnt_q[1]) + 16'h0001)))
    else $error("counter did not step by one");
  a_disabled_low: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE23
    (en_i && !run && !stat_q[ppg_pkg::TRIP_BIT] && !trip_fall) |=> (pwm_o == 8'h00))
    else $error("disabled outputs not low");
  a_pair3_std: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE2
    (en_i && run && !trip_fall) |=> (pwm_o[7:6] == {$past(ls_q[3]), $past(hs_q[3])}))
    else $error("pair 3 not in standard mode");
  a_wrap_irq_set: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE24
    (en_i && wrap[3] && ien) |=> irq_pair_o[3])
    else $error("wrap interrupt missing");
  a_load_clears: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE22
    (en_i && load_done && !(bus_i.we && hit_ctrl)) |=> !ctrl_q[ppg_pkg::LOAD_BIT])
    else $error("load bit not cleared");
  a_prescale_div: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE7
    (en_i && pre_tick && clock_divider_control_i == 3'h0 && pre_sel == 3'h0) |=> !pre_tick)
    else $error("prescale too fast");

  // Reset mode, edge points, bridge rows, trip hold and register port
  a_reset_bridge: assert property (@(posedge clk_i) // see RULE3
    !nrst_i |=> ctrl_q[ppg_pkg::BRIDGE_MODE_SELECT_BIT])
    else $error("bridge mode not selected by reset");
  a_high_rise_cmp: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE14
    (en_i && run && pre_tick && (cnt_q[3] == active_q[3].com0) && (cnt_q[3] != active_q[3].com1))
    |=> hs_q[3])
    else $error("high side did not rise at first compare");
  a_low_rise_len: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE12
    (en_i && run && pre_tick && (cnt_q[3] == active_q[3].len)
    && (cnt_q[3] != active_q[3].com2) && (cnt_q[3] != active_q[3].com1))
    |=> ls_q[3])
    else $error("low side did not rise at period length");
  a_low_follows_high: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE13
    (en_i && run && pre_tick && hs_q[2] && (cnt_q[2] == active_q[2].com1))
    |=> !ls_q[2])
    else $error("low side stayed high after high side fell");
  a_bridge_brake: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE2
    (en_i && run && bridge && !b_hoff && !b_ena && !trip_fall)
    |=> (pwm_o[3:0] == 4'hF))
    else $error("bridge brake row wrong");
  a_bridge_free: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE2
    (en_i && run && bridge && b_hoff && !trip_fall)
    |=> (pwm_o[3:0] == 4'h5))
    else $error("bridge free run row wrong");
  a_trip_hold_off: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE5
    (en_i && stat_q[ppg_pkg::TRIP_BIT] && !run)
    |=> (pwm_o == ppg_pkg::OUT_OFF))
    else $error("off state not held after trip");
  a_stat_clear: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE24
    (en_i && bus_i.we && hit_stat && bus_i.wdata[0] && !wrap_irq[0])
    |=> !irq_pair_o[0])
    else $error("pair flag not cleared by write");
  a_read_ctrl: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && bus_i.re && hit_ctrl)
    |=> (rdata_o == $past(ctrl_q)))
    else $error("control readback wrong");
  a_read_idle_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (en_i && !bus_i.re)
    |=> (rdata_o == 16'h0000))
    else $error("read data did not return to zero");

  c_trip_seen: cover property (@(posedge clk_i) disable iff (!nrst_i) trip_fall);
  c_pair_wrap: cover property (@(posedge clk_i) disable iff (!nrst_i) wrap[0] && ien);
  c_bridge_run: cover property (@(posedge clk_i) disable iff (!nrst_i) run && bridge && b_ena && !b_hoff);
  c_load_done: cover property (@(posedge clk_i) disable iff (!nrst_i) load_done);
  c_free_run: cover property (@(posedge clk_i) disable iff (!nrst_i) run && bridge && b_hoff);

endmodule : ppg_core

// >>> core/ppg_pkg.sv
// Package for the paired PWM generator: register map, control fields, carriers
package ppg_pkg;

  // Geometry
  localparam int unsigned NPAIR = 4;
  localparam int unsigned DW = 16;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] PAIR_BASE = 8'h10;
  localparam logic [7:0] CNT_BASE = 8'h50;
  localparam logic [7:0] CNT_END = 8'h60;

  // Control register fields
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned BRIDGE_MODE_SELECT_BIT = 1;
  localparam int unsigned DIR_BIT = 2;
  localparam int unsigned LOAD_BIT = 3;
  localparam int unsigned HOFF_BIT = 4;
  localparam int unsigned POINV_BIT = 5;
  localparam int unsigned PRE_LSB = 6;
  localparam int unsigned PRE_MSB = 8;
  localparam int unsigned ENA_BIT = 9;
  localparam int unsigned IEN_BIT = 10;
  localparam logic [15:0] CTRL_RST = 16'h0012;
  localparam logic [15:0] CTRL_MASK = 16'h07FF;

  // Status register fields: bits 3..0 pair wrap, bit 4 trip
  localparam int unsigned TRIP_BIT = 4;
  localparam logic [4:0] STAT_RST = 5'h00;

  // Output patterns
  localparam logic [7:0] OUT_OFF = 8'h55;
  localparam logic [7:0] OUT_RST = 8'h00;

  // Compare set of one pair, field index 0..3 = rise, fall, low fall, length
  typedef struct packed {
    logic [15:0] len;
    logic [15:0] com2;
    logic [15:0] com1;
    logic [15:0] com0;
  } ppg_pair_s;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
  } ppg_bus_s;

  // Low-bit mask of width sh, used by both clock dividers
  function automatic logic [7:0] ppg_mask(input logic [3:0] sh);
    ppg_mask = 8'((16'h0001 << sh) - 16'h0001);
  endfunction : ppg_mask

endpackage : ppg_pkg

// >>> verif/ppg_gate_drv.sv
// Gate driver model: measures output pulses and pulls the fault line
`timescale 1ns/100ps
module ppg_gate_drv (
  // Clock
  input wire logic clk_i,
  // Modulated outputs from the generator
  input wire logic [7:0] pwm_i,
  // Fault request from the bench, active high
  input wire logic fault_i,
  // Trip line, pulled up while no fault
  output logic fault_trip_input_o
);
  int unsigned cyc = 0;
  int unsigned rise_t [8];
  int unsigned per [8];
  int unsigned hi [8];
  logic [7:0] prev = 8'h00;

  // Released line sits at its pull-up level
  assign fault_trip_input_o = fault_i ? 1'b0 : 1'b1;

  // Rise to rise gives period, rise to fall gives high time
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    prev <= pwm_i;
    for (int i = 0; i < 8; i++) begin
      if (pwm_i[i] && !prev[i]) begin
        per[i] <= cyc - rise_t[i];
        rise_t[i] <= cyc;
      end
      if (!pwm_i[i] && prev[i]) hi[i] <= cyc - rise_t[i];
    end
  end
endmodule : ppg_gate_drv

// >>> verif/paired_pwm_generator_tb.sv
// Self-checking bench for the paired PWM generator
`timescale 1ns/100ps
module paired_pwm_generator_tb;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  ppg_pkg::ppg_bus_s bus = '0;
  logic [15:0] rdata;
  logic [2:0] div_sel = 3'h0;
  logic fault = 1'b0;
  logic trip_n;
  logic [7:0] pwm;
  logic irq_trip;
  logic [3:0] irq_pair;
  logic [15:0] rv;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #4 clk_i = ~clk_i;

  ppg_core i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(1'b1), .bus_i(bus), .rdata_o(rdata),
    .clock_divider_control_i(div_sel), .fault_trip_input_i(trip_n), .pwm_o(pwm),
    .irq_trip_o(irq_trip), .irq_pair_o(irq_pair));
  ppg_gate_drv i_drv (.clk_i(clk_i), .pwm_i(pwm), .fault_i(fault), .fault_trip_input_o(trip_n));

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  // Hang guard, well above the longest prescale run
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk_i);
    bus.we <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
    @(posedge clk_i);
    bus.re <= 1'b0;
    #1 rv = rdata;
  endtask : rd

  task automatic waitc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : waitc

  initial begin
    waitc(5);
    nrst_i <= 1'b1;
    // Reset state and refused addresses
    rd(ppg_pkg::CTRL_OFS);
    chk("ctrl", rv, 16'h0012);
    rd(ppg_pkg::STAT_OFS);
    chk("stat", rv, 16'h0000);
    rd(8'h04);
    chk("unmapped", rv, 16'h0000);
    rd(ppg_pkg::CNT_BASE);
    chk("cnt0", rv, 16'h0000);
    chk("pwm rst", {8'h00, pwm}, 16'h0000);
    $display("Test reset done");
    // Standard mode, high time 4 ticks kept above low-side high time
    for (int n = 0; n < 4; n++) begin
      wr(8'(8'h10 + 16 * n), 16'h0002);
      wr(8'(8'h14 + 16 * n), 16'h0006);
      wr(8'(8'h18 + 16 * n), 16'h0001);
      wr(8'(8'h1C + 16 * n), 16'(8 + 4 * n));
    end
    wr(ppg_pkg::CTRL_OFS, 16'h0008);
    rd(ppg_pkg::CTRL_OFS);
    chk("load clear", rv, 16'h0000);
    wr(ppg_pkg::CTRL_OFS, 16'h0401);
    waitc(200);
    for (int n = 0; n < 4; n++) begin
      chk("per hs", 16'(i_drv.per[2 * n]), 16'((9 + 4 * n) * 2));
      chk("per ls", 16'(i_drv.per[2 * n + 1]), 16'((9 + 4 * n) * 2));
      chk("hi hs", 16'(i_drv.hi[2 * n]), 16'h0008);
    end
    chk("irq pair", {12'h000, irq_pair}, 16'h000F);
    $display("Test standard done");
    // Disable, then clear pair flags
    wr(ppg_pkg::CTRL_OFS, 16'h0000);
    waitc(4);
    chk("pwm off", {8'h00, pwm}, 16'h0000);
    wr(ppg_pkg::STAT_OFS, 16'h000F);
    rd(ppg_pkg::STAT_OFS);
    chk("stat clr", rv, 16'h0000);
    chk("irq clr", {12'h000, irq_pair}, 16'h0000);
    $display("Test clear done");
    // Every prescale code on pair 0
    for (int c = 0; c < 8; c++) begin
      wr(ppg_pkg::CTRL_OFS, 16'h0001 | 16'(c << ppg_pkg::PRE_LSB));
      waitc(27 * (2 << c) + 20);
      chk("prescale", 16'(i_drv.per[0]), 16'(9 * (2 << c)));
    end
    $display("Test prescale done");
    // Base divider code 1 halves the count clock
    div_sel <= 3'h1;
    wr(ppg_pkg::CTRL_OFS, 16'h0001);
    waitc(150);
    chk("base div", 16'(i_drv.per[0]), 16'(9 * 4));
    div_sel <= 3'h0;
    $display("Test base divider done");
    // Bridge brake row, pair 2 stays standard
    wr(ppg_pkg::CTRL_OFS, 16'h0003);
    waitc(200);
    chk("bridge", {12'h000, pwm[3:0]}, 16'h000F);
    chk("pair2 std", 16'(i_drv.per[4]), 16'(17 * 2));
    // Free run row, then pair 0 waveforms steered by direction and invert
    wr(ppg_pkg::CTRL_OFS, 16'h0013);
    waitc(4);
    chk("bridge free", {12'h000, pwm[3:0]}, 16'h0005);
    wr(ppg_pkg::CTRL_OFS, 16'h0207);
    waitc(100);
    chk("bridge dir", {14'h0000, pwm[3:2]}, 16'h0000);
    chk("bridge dir per", 16'(i_drv.per[0]), 16'(9 * 2));
    wr(ppg_pkg::CTRL_OFS, 16'h0223);
    waitc(100);
    chk("bridge inv", {14'h0000, pwm[3:2]}, 16'h0003);
    chk("bridge inv per", 16'(i_drv.per[1]), 16'(9 * 2));
    $display("Test bridge done");
    // Fault trip mid-period
    wr(ppg_pkg::CTRL_OFS, 16'h0001);
    waitc(23);
    fault <= 1'b1;
    waitc(4);
    chk("trip out", {8'h00, pwm}, {8'h00, ppg_pkg::OUT_OFF});
    chk("trip irq", {15'h0000, irq_trip}, 16'h0001);
    fault <= 1'b0;
    rd(ppg_pkg::CTRL_OFS);
    chk("trip en", {15'h0000, rv[ppg_pkg::EN_BIT]}, 16'h0000);
    waitc(40);
    chk("trip hold", {8'h00, pwm}, {8'h00, ppg_pkg::OUT_OFF});
    $display("Test trip done");
    // Reset in mid-run brings back the power-up state
    nrst_i <= 1'b0;
    waitc(5);
    nrst_i <= 1'b1;
    rd(ppg_pkg::CTRL_OFS);
    chk("ctrl again", rv, 16'h0012);
    chk("pwm again", {8'h00, pwm}, 16'h0000);
    chk("trip irq again", {15'h0000, irq_trip}, 16'h0000);
    $display("Test mid-run reset done");
    complete_run();
  end
endmodule : paired_pwm_generator_tb
